/* File: ext_exec_pkg.sv */
// Constants and types for the extended-instruction execution block
package ext_exec_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int NIBBLE_W = 4;
  localparam int PWORD_W = 16;
  localparam int PADDR_W = 16;
  localparam int AXI_AW = 5;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [AXI_AW-1:0] ACC_OFS = 5'h00;
  localparam logic [AXI_AW-1:0] PTR_LOWER_OFS = 5'h04;
  localparam logic [AXI_AW-1:0] PTR_UPPER_OFS = 5'h08;
  localparam logic [AXI_AW-1:0] HIGH_LATCH_OFS = 5'h0c;
  localparam logic [AXI_AW-1:0] STATUS_OFS = 5'h10;

  // Status fields
  localparam int STAT_NULL_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;

  // Reset value, zero constant and pointer step
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [BYTE_W-1:0] PTR_STEP = 8'h01;
  // Final program page: upper pointer bits all ones
  localparam logic [BYTE_W-1:0] FINAL_PAGE = 8'hff;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Operations and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    nibble_exchange_in_place,
    nibble_exchange_to_accumulator,
    skip_on_null_value,
    skip_on_null_with_move,
    skip_on_null_bit,
    table_fetch_chosen_page,
    table_fetch_final_page,
    table_fetch_chosen_page_preinc,
    table_fetch_final_page_preinc,
    exclusive_or_into_accumulator,
    exclusive_or_into_memory
  } ext_op_t;

  typedef enum logic [1:0] {
    st_idle,
    st_exec,
    st_commit,
    st_dummy
  } seq_state_t;

endpackage

/* File: ext_swap_skip_table_xor_exec.sv */
// Execution unit for nibble swap, zero skip, table read and XOR operations
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps

// Operation
// - In-place swap writes the byte back with nibbles exchanged, no flags.
// - Accumulator swap loads the exchanged byte into ACC, memory intact.
// - Byte skip reads, rewrites the same byte and skips when it is zero.
// - A taken skip adds one dummy cycle, three cycles in all.
// - Skip-with-move copies the byte to ACC and skips when it is zero.
// - Bit skip tests the selected bit and skips when it is zero.
// - A nonzero tested value or bit continues with no skip.
// - Chosen-page table read uses both pointers, low byte to memory.
// - Final-page table read uses the final page and the lower pointer.
// - Chosen-page preincrement read bumps the lower pointer first.
// - Final-page preincrement read bumps first; table reads keep flags.
// - XOR into ACC stores ACC^byte in ACC, updating only null flag.
// - XOR into memory stores ACC^byte in the byte, only null flag.
module ext_swap_skip_table_xor_exec
  import ext_exec_pkg::*;
#(
  parameter int DADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  // Core issue port
  input wire logic issue_valid,
  output logic issue_ready,
  input wire ext_op_t issue_op,
  input wire logic [DADDR_W-1:0] issue_addr,
  input wire logic [2:0] issue_bit,
  output logic done,
  output logic skip_next,
  output logic dummy_cycle,
  // Data memory, combinational read
  output logic dm_rd_en,
  output logic [DADDR_W-1:0] dm_addr,
  input wire logic [BYTE_W-1:0] dm_rdata,
  output logic dm_we,
  output logic [BYTE_W-1:0] dm_wdata,
  // Program memory, combinational read
  output logic pm_rd_en,
  output logic [PADDR_W-1:0] pm_addr,
  input wire logic [PWORD_W-1:0] pm_rdata,
  // AXI4-Lite slave
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  seq_state_t state, next_state;
  ext_op_t op, next_op;
  logic [2:0] bit_sel, next_bit_sel;
  logic [BYTE_W-1:0] acc, next_acc;
  logic [BYTE_W-1:0] ptr_lower, next_ptr_lower;
  logic [BYTE_W-1:0] ptr_upper, next_ptr_upper;
  logic [BYTE_W-1:0] high_latch, next_high_latch;
  logic null_flag, next_null_flag;
  logic next_done, next_skip, next_dummy;
  logic next_dm_rd, next_dm_we, next_pm_rd;
  logic [DADDR_W-1:0] next_dm_addr;
  logic [BYTE_W-1:0] next_dm_wdata;
  logic [PADDR_W-1:0] next_pm_addr;
  logic [BYTE_W-1:0] rd_swap, xor_res, ptr_use;
  logic is_table, is_preinc, is_final;
  logic wr_fire, wr_low, rd_fire;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;

  assign rd_swap = {dm_rdata[NIBBLE_W-1:0], dm_rdata[BYTE_W-1:NIBBLE_W]};
  assign xor_res = acc ^ dm_rdata;
  assign issue_ready = (state == st_idle);
  assign is_table = (issue_op == table_fetch_chosen_page) ||
                    (issue_op == table_fetch_final_page) ||
                    (issue_op == table_fetch_chosen_page_preinc) ||
                    (issue_op == table_fetch_final_page_preinc);
  assign is_preinc = (issue_op == table_fetch_chosen_page_preinc) ||
                     (issue_op == table_fetch_final_page_preinc);
  assign is_final = (issue_op == table_fetch_final_page) ||
                    (issue_op == table_fetch_final_page_preinc);

  // ----------------------------------------------------------------
  // Sequencer and datapath
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_op = op;
    next_bit_sel = bit_sel;
    next_acc = acc;
    next_ptr_lower = ptr_lower;
    next_ptr_upper = ptr_upper;
    next_high_latch = high_latch;
    next_null_flag = null_flag;
    next_done = 1'b0;
    next_skip = 1'b0;
    next_dummy = 1'b0;
    next_dm_rd = 1'b0;
    next_dm_we = 1'b0;
    next_pm_rd = 1'b0;
    next_dm_addr = dm_addr;
    next_dm_wdata = dm_wdata;
    next_pm_addr = pm_addr;
    ptr_use = ptr_lower;
    // Software writes first so a same-cycle hardware update wins
    if (wr_low && s_axi_awaddr == ACC_OFS) begin
      next_acc = s_axi_wdata[BYTE_W-1:0];
    end
    if (wr_low && s_axi_awaddr == PTR_LOWER_OFS) begin
      next_ptr_lower = s_axi_wdata[BYTE_W-1:0];
    end
    if (wr_low && s_axi_awaddr == PTR_UPPER_OFS) begin
      next_ptr_upper = s_axi_wdata[BYTE_W-1:0];
    end
    unique case (state)
      st_idle: begin
        if (issue_valid) begin
          next_op = issue_op;
          next_bit_sel = issue_bit;
          next_dm_addr = issue_addr;
          next_state = st_exec;
          if (is_table) begin
            if (is_preinc) begin
              ptr_use = ptr_lower + PTR_STEP;
              next_ptr_lower = ptr_use;
            end
            if (is_final) begin
              next_pm_addr = {FINAL_PAGE, ptr_use};
            end else begin
              next_pm_addr = {ptr_upper, ptr_use};
            end
            next_pm_rd = 1'b1;
          end else begin
            next_dm_rd = 1'b1;
          end
        end
      end
      st_exec: begin
        next_state = st_commit;
        unique case (op)
          nibble_exchange_in_place: begin
            next_dm_we = 1'b1;
            next_dm_wdata = rd_swap;
          end
          nibble_exchange_to_accumulator: begin
            next_acc = rd_swap;
          end
          skip_on_null_value: begin
            next_dm_we = 1'b1;
            next_dm_wdata = dm_rdata;
            next_skip = (dm_rdata == BYTE_ZERO);
          end
          skip_on_null_with_move: begin
            next_acc = dm_rdata;
            next_skip = (dm_rdata == BYTE_ZERO);
          end
          skip_on_null_bit: begin
            next_skip = ~dm_rdata[bit_sel];
          end
          exclusive_or_into_accumulator: begin
            next_acc = xor_res;
            next_null_flag = (xor_res == BYTE_ZERO);
          end
          exclusive_or_into_memory: begin
            next_dm_we = 1'b1;
            next_dm_wdata = xor_res;
            next_null_flag = (xor_res == BYTE_ZERO);
          end
          default: begin
            // Table fetches: low byte to memory, high byte to the latch
            next_dm_we = 1'b1;
            next_dm_wdata = pm_rdata[BYTE_W-1:0];
            next_high_latch = pm_rdata[PWORD_W-1:BYTE_W];
          end
        endcase
        next_done = ~next_skip;
      end
      st_commit: begin
        // The dummy slot covers the fetch of the instruction being skipped
        next_state = skip_next ? st_dummy : st_idle;
        next_dummy = skip_next;
        next_done = skip_next;
      end
      st_dummy: begin
        next_state = st_idle;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= st_idle;
      op <= nibble_exchange_in_place;
      bit_sel <= 3'h0;
      acc <= BYTE_RST;
      ptr_lower <= BYTE_RST;
      ptr_upper <= BYTE_RST;
      high_latch <= BYTE_RST;
      null_flag <= 1'b0;
      done <= 1'b0;
      skip_next <= 1'b0;
      dummy_cycle <= 1'b0;
      dm_rd_en <= 1'b0;
      dm_we <= 1'b0;
      pm_rd_en <= 1'b0;
      dm_addr <= '0;
      dm_wdata <= BYTE_RST;
      pm_addr <= '0;
    end else begin
      state <= next_state;
      op <= next_op;
      bit_sel <= next_bit_sel;
      acc <= next_acc;
      ptr_lower <= next_ptr_lower;
      ptr_upper <= next_ptr_upper;
      high_latch <= next_high_latch;
      null_flag <= next_null_flag;
      done <= next_done;
      skip_next <= next_skip;
      dummy_cycle <= next_dummy;
      dm_rd_en <= next_dm_rd;
      dm_we <= next_dm_we;
      pm_rd_en <= next_pm_rd;
      dm_addr <= next_dm_addr;
      dm_wdata <= next_dm_wdata;
      pm_addr <= next_pm_addr;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  // Address and data are taken together; one response is outstanding
  assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign wr_low = wr_fire && s_axi_wstrb[0];
  assign s_axi_awready = wr_fire;
  assign s_axi_wready = wr_fire;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && !s_axi_rvalid;

  always_comb begin
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    if (wr_fire) begin
      next_bvalid = 1'b1;
      next_bresp = (s_axi_awaddr > STATUS_OFS ||
                    s_axi_awaddr[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
    end
    if (rd_fire) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = '0;
      unique case (s_axi_araddr)
        ACC_OFS: next_rdata[BYTE_W-1:0] = acc;
        PTR_LOWER_OFS: next_rdata[BYTE_W-1:0] = ptr_lower;
        PTR_UPPER_OFS: next_rdata[BYTE_W-1:0] = ptr_upper;
        HIGH_LATCH_OFS: next_rdata[BYTE_W-1:0] = high_latch;
        STATUS_OFS: begin
          next_rdata[STAT_NULL_BIT] = null_flag;
          next_rdata[STAT_BUSY_BIT] = (state != st_idle);
        end
        default: next_rresp = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= '0;
    end else begin
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_swap_in_place: assert property (
    state == st_commit && op == nibble_exchange_in_place |->
      dm_we && dm_wdata == $past(rd_swap) && $stable(null_flag))
    else $error("in-place swap wrote wrong byte");

  a_swap_to_acc: assert property (
    state == st_commit && op == nibble_exchange_to_accumulator |->
      !dm_we && acc == $past(rd_swap) && $stable(null_flag))
    else $error("accumulator swap wrong");

  a_skip_value: assert property (
    state == st_commit && op == skip_on_null_value |->
      dm_we && dm_wdata == $past(dm_rdata) &&
      skip_next == ($past(dm_rdata) == BYTE_ZERO))
    else $error("byte skip wrong");

  a_skip_dummy: assert property (
    state == st_commit && skip_next |=>
      dummy_cycle && done ##1 !dummy_cycle && issue_ready)
    else $error("taken skip not three cycles");

  a_skip_move: assert property (
    state == st_commit && op == skip_on_null_with_move |->
      acc == $past(dm_rdata) && !dm_we &&
      skip_next == ($past(dm_rdata) == BYTE_ZERO))
    else $error("skip with move wrong");

  a_skip_bit: assert property (
    state == st_commit && op == skip_on_null_bit |->
      !dm_we && skip_next == !$past(dm_rdata[bit_sel]))
    else $error("bit skip wrong");

  a_no_skip: assert property (
    state == st_commit && !skip_next |->
      done ##1 state == st_idle && !dummy_cycle)
    else $error("untaken skip delayed");

  a_table_chosen: assert property (
    state == st_idle && issue_valid &&
    issue_op == table_fetch_chosen_page |=>
      pm_rd_en && pm_addr == {$past(ptr_upper), $past(ptr_lower)}
      ##1 dm_we && dm_wdata == $past(pm_rdata[BYTE_W-1:0]) &&
      high_latch == $past(pm_rdata[PWORD_W-1:BYTE_W]))
    else $error("chosen page table read wrong");

  a_table_final: assert property (
    state == st_idle && issue_valid && issue_op == table_fetch_final_page
    |=> pm_addr == {FINAL_PAGE, $past(ptr_lower)} ##1
      high_latch == $past(pm_rdata[PWORD_W-1:BYTE_W]))
    else $error("final page table read wrong");

  a_table_preinc: assert property (
    state == st_idle && issue_valid && is_preinc && !wr_fire |=>
      ptr_lower == $past(ptr_lower) + PTR_STEP &&
      ptr_upper == $past(ptr_upper) && pm_addr[BYTE_W-1:0] == ptr_lower
      ##1 $stable(null_flag) ##1 $stable(null_flag))
    else $error("preincrement table read wrong");

  a_xor_acc: assert property (
    state == st_commit && op == exclusive_or_into_accumulator |->
      acc == $past(xor_res) && !dm_we &&
      null_flag == ($past(xor_res) == BYTE_ZERO))
    else $error("xor into accumulator wrong");

  a_xor_mem: assert property (
    state == st_commit && op == exclusive_or_into_memory |->
      dm_we && dm_wdata == $past(xor_res) &&
      null_flag == (dm_wdata == BYTE_ZERO))
    else $error("xor into memory wrong");

endmodule // ext_swap_skip_table_xor_exec

/* File: mem_model.sv */
// Behavioural data and program memory facing the execution block
`timescale 1ns/1ps
module mem_model
  import ext_exec_pkg::*;
(
  input wire logic aclk,
  input wire logic dm_rd_en,
  input wire logic [7:0] dm_addr,
  input wire logic dm_we,
  input wire logic [BYTE_W-1:0] dm_wdata,
  output logic [BYTE_W-1:0] dm_rdata,
  input wire logic pm_rd_en,
  input wire logic [PADDR_W-1:0] pm_addr,
  output logic [PWORD_W-1:0] pm_rdata
);
  logic [BYTE_W-1:0] mem [256];
  logic [BYTE_W-1:0] last_d = 8'h00;
  logic [PWORD_W-1:0] last_p = 16'h0000;
  logic [PWORD_W-1:0] word;

  // Program word is a fixed scramble of its own address
  assign word = {pm_addr[15:8] + pm_addr[7:0], pm_addr[7:0] ^ 8'h3c};
  // Deselected lines show the inverse of the last value, never a stale copy
  assign dm_rdata = dm_rd_en ? mem[dm_addr] : ~last_d;
  assign pm_rdata = pm_rd_en ? word : ~last_p;

  always @(posedge aclk) begin
    if (dm_we) mem[dm_addr] <= dm_wdata;
    if (dm_rd_en) last_d <= mem[dm_addr];
    if (pm_rd_en) last_p <= word;
  end
endmodule // mem_model

/* File: tb_top.sv */
// Self-checking bench for the extended-instruction execution block
`timescale 1ns/1ps
module tb_top;
  import ext_exec_pkg::*;
  typedef struct {
    logic we;
    logic [7:0] wd;
    logic [7:0] a;
    logic sk;
    int t0;
  } note_t;
  logic aclk, aresetn, issue_valid, issue_ready, done, skip_next, dummy_cycle;
  ext_op_t issue_op, op;
  logic [7:0] issue_addr, dm_addr, dm_rdata, dm_wdata, a, v;
  logic [7:0] acc, lo, hi, latch;
  logic [2:0] issue_bit, b;
  logic dm_rd_en, dm_we, pm_rd_en, flag;
  logic [15:0] pm_addr, pm_rdata, pa;
  logic [4:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [33:0] an;
  logic seen_we = 0, seen_sk = 0;
  logic [7:0] seen_wd, seen_a;
  int n_mismatch = 0, n_tests = 0, cyc = 0;
  integer seed = 32'h3c532d14;
  note_t iq[$], nd, nm;
  logic [33:0] aq[$];

  ext_swap_skip_table_xor_exec ext_swap_skip_table_xor_exec_inst (
    .aclk(aclk), .aresetn(aresetn), .issue_valid(issue_valid),
    .issue_ready(issue_ready), .issue_op(issue_op),
    .issue_addr(issue_addr), .issue_bit(issue_bit), .done(done),
    .skip_next(skip_next), .dummy_cycle(dummy_cycle),
    .dm_rd_en(dm_rd_en), .dm_addr(dm_addr), .dm_rdata(dm_rdata),
    .dm_we(dm_we), .dm_wdata(dm_wdata), .pm_rd_en(pm_rd_en),
    .pm_addr(pm_addr), .pm_rdata(pm_rdata), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  mem_model mem_model_inst (
    .aclk(aclk), .dm_rd_en(dm_rd_en), .dm_addr(dm_addr), .dm_we(dm_we),
    .dm_wdata(dm_wdata), .dm_rdata(dm_rdata), .pm_rd_en(pm_rd_en),
    .pm_addr(pm_addr), .pm_rdata(pm_rdata));

  initial begin
    aclk = 0;
    forever #12.5 aclk = ~aclk;
  end

  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic check(logic [31:0] seen, logic [31:0] exp, string what);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %0t: %s seen %h expected %h",
               $time, what, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Hang guard: the whole sequence needs under two thousand cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  // Results are gathered over commit and dummy cycles, judged at done
  always @(posedge aclk) begin
    if (dm_we === 1'b1) begin
      seen_we = 1;
      seen_wd = dm_wdata;
      seen_a = dm_addr;
    end
    if (skip_next === 1'b1) seen_sk = 1;
    if (done === 1'b1) begin
      nm = iq.pop_front();
      check(seen_we, nm.we, "write strobe");
      if (nm.we) begin
        check(seen_wd, nm.wd, "write data");
        check(seen_a, nm.a, "write address");
      end
      check(seen_sk, nm.sk, "skip");
      check(dummy_cycle, nm.sk, "dummy cycle");
      check(cyc - nm.t0, nm.sk ? 3 : 2, "length");
      seen_we = 0;
      seen_sk = 0;
    end
    if (bvalid === 1'b1 && bready) begin
      an = aq.pop_front();
      check(bresp, an[33:32], "write response");
    end
    if (rvalid === 1'b1 && rready) begin
      an = aq.pop_front();
      check(rresp, an[33:32], "read response");
      check(rdata, an[31:0], "read data");
    end
  end

  // ------------------------------------------------------------
  // Drivers
  // ------------------------------------------------------------
  task automatic axi_wr(logic [4:0] ad, logic [7:0] d, logic [1:0] r);
    logic aw_left;
    logic w_left;
    aw_left = 1'b1;
    w_left = 1'b1;
    awaddr <= ad;
    wdata <= {24'($random(seed)), d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aq.push_back({r, 32'h0});
    // Each channel is released on its own ready
    while (aw_left || w_left) begin
      @(posedge aclk);
      if (aw_left && awready === 1'b1) begin
        aw_left = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_left && wready === 1'b1) begin
        w_left = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(logic [4:0] ad, logic [7:0] d, logic [1:0] r);
    araddr <= ad;
    arvalid <= 1;
    aq.push_back({r, 24'h0, d});
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    rready <= 1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 0;
  endtask

  task automatic regs();
    axi_rd(ACC_OFS, acc, RESP_OKAY);
    axi_rd(PTR_LOWER_OFS, lo, RESP_OKAY);
    axi_rd(PTR_UPPER_OFS, hi, RESP_OKAY);
    axi_rd(HIGH_LATCH_OFS, latch, RESP_OKAY);
    axi_rd(STATUS_OFS, {7'h0, flag}, RESP_OKAY);
  endtask

  task automatic run_op(note_t n);
    issue_op <= op;
    issue_addr <= a;
    issue_bit <= b;
    issue_valid <= 1;
    do @(posedge aclk); while (issue_ready !== 1'b1);
    n.t0 = cyc;
    iq.push_back(n);
    issue_valid <= 0;
    do @(posedge aclk); while (done !== 1'b1);
  endtask

  initial begin
    {aresetn, issue_valid, issue_addr, issue_bit, awaddr, araddr} = '0;
    {awvalid, wvalid, wdata, bready, arvalid, rready} = '0;
    {acc, lo, hi, latch, flag} = '0;
    issue_op = nibble_exchange_in_place;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    regs();
    axi_rd(5'h14, 8'h00, RESP_SLVERR);
    axi_wr(5'h02, 8'h11, RESP_SLVERR);
    axi_wr(HIGH_LATCH_OFS, 8'h5a, RESP_OKAY);
    axi_wr(STATUS_OFS, 8'h01, RESP_OKAY);
    regs();
    for (int i = 0; i < 44; i++) begin
      op = ext_op_t'(i % 11);
      a = 8'($random(seed));
      b = 3'($random(seed));
      // Software load of the accumulator feeds the two XOR paths
      if (i % 3 == 0) begin
        acc = 8'($random(seed));
        axi_wr(ACC_OFS, acc, RESP_OKAY);
      end
      case ($random(seed) & 3)
        0: v = 8'h00;
        1: v = acc;
        default: v = 8'($random(seed));
      endcase
      lo = (i % 4 == 0) ? 8'hff : 8'($random(seed));
      hi = 8'($random(seed));
      axi_wr(PTR_LOWER_OFS, lo, RESP_OKAY);
      axi_wr(PTR_UPPER_OFS, hi, RESP_OKAY);
      mem_model_inst.mem[a] = v;
      nd = '{0, v, a, 0, 0};
      case (op)
        nibble_exchange_in_place: begin
          nd.we = 1;
          nd.wd = {v[3:0], v[7:4]};
        end
        nibble_exchange_to_accumulator: acc = {v[3:0], v[7:4]};
        skip_on_null_value: begin
          nd.we = 1;
          nd.sk = (v == 8'h00);
        end
        skip_on_null_with_move: begin
          acc = v;
          nd.sk = (v == 8'h00);
        end
        skip_on_null_bit: nd.sk = !v[b];
        exclusive_or_into_accumulator: begin
          acc = acc ^ v;
          flag = (acc == 8'h00);
        end
        exclusive_or_into_memory: begin
          nd.we = 1;
          nd.wd = acc ^ v;
          flag = (nd.wd == 8'h00);
        end
        default: begin
          if (op == table_fetch_chosen_page_preinc ||
              op == table_fetch_final_page_preinc) lo = lo + 8'h01;
          pa = {(op == table_fetch_final_page ||
                 op == table_fetch_final_page_preinc) ? FINAL_PAGE : hi,
                lo};
          nd.we = 1;
          nd.wd = pa[7:0] ^ 8'h3c;
          latch = pa[15:8] + pa[7:0];
        end
      endcase
      run_op(nd);
      regs();
    end
    // Mid-run reset must bring every register back to zero
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    {acc, lo, hi, latch, flag} = '0;
    @(posedge aclk);
    regs();
    repeat (4) @(posedge aclk);
    check(iq.size() + aq.size(), 0, "pending results");
    print_verdict();
  end
endmodule // tb_top
